// ==== common/mode_pin_regs.svh ====
`ifndef MODE_PIN_REGS_SVH
`define MODE_PIN_REGS_SVH

// Register byte offsets
`define REG_MODE_STATUS   12'h000
`define REG_RESET_CTRL    12'h004
`define REG_PULLUP_A      12'h008
`define REG_PULLUP_B      12'h00c
`define REG_BOOT_NVM      12'h010

// Mode status fields
`define FLD_SCAN          0
`define FLD_TEST          1
`define FLD_FFP           2
`define FLD_MFG_TEST      3
`define FLD_STRAP_BAD     4
`define FLD_WIPE_DONE     5
`define FLD_RST_PIN_LOW   6

// Reset control fields
`define FLD_SW_RESET      0

// Boot nvm bit position
`define FLD_BOOT_FLASH    2

// Reset values
`define RST_PULLUP        31'h7fffffff
`define RST_BOOT_NVM      3'h0

// Timing
`define CLK_HZ            40000000
`define SLOW_HZ           32000
`define WIPE_MS           200
`define WIPE_SLOW_TICKS   ((`WIPE_MS * `SLOW_HZ + 999) / 1000)
`define SLOW_DIV          (`CLK_HZ / `SLOW_HZ)
`define RST_PULSE_NS      1000
`define RST_PULSE_CYC     ((`RST_PULSE_NS + 24) / 25)

`endif

// ==== common/mode_pin_pkg.sv ====
`default_nettype none
package mode_pin_pkg;
	typedef enum logic [1:0] {
		op_normal,
		op_scan,
		op_mfg_test,
		op_fast_prog
	} op_mode_t;
	typedef enum logic [1:0] {
		rst_idle,
		rst_drive,
		rst_wait_release
	} rst_state_t;
endpackage
`default_nettype wire

// ==== hw/sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] reset_value,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// First stage feeds only the second
	// Bits set in reset_value come out inverted, so idle-high pins read 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in ^ reset_value;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// ==== hw/wipe_debounce.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mode_pin_regs.svh"
module wipe_debounce #(
	parameter int SLOW_DIV   = `SLOW_DIV,
	parameter int WIPE_TICKS = `WIPE_SLOW_TICKS
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic wipe_level,
	output logic      wipe_fire
);
	logic [15:0] div_count;
	logic        slow_tick;
	logic [15:0] held;
	logic        fired;

	// Slow RC rate made from the main clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_count <= 16'h0000;
			slow_tick <= 1'b0;
		end else if (div_count == 16'(SLOW_DIV - 1)) begin
			div_count <= 16'h0000;
			slow_tick <= 1'b1;
		end else begin
			div_count <= div_count + 16'h0001;
			slow_tick <= 1'b0;
		end
	end

	// Any drop restarts the count; one fire per assertion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held      <= 16'h0000;
			fired     <= 1'b0;
			wipe_fire <= 1'b0;
		end else begin
			wipe_fire <= 1'b0;
			if (!wipe_level) begin
				held  <= 16'h0000;
				fired <= 1'b0;
			end else if (slow_tick && !fired) begin
				if (held == 16'(WIPE_TICKS - 1)) begin
					fired     <= 1'b1;
					wipe_fire <= 1'b1;
				end else begin
					held <= held + 16'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== hw/mode_pin_reset_control.sv ====
// How it works
// - Scan-select high enters boundary scan
// - Test-mode high enters test or fast programming
// - Controller pulls open-drain reset pin low
// - External low on reset pin asserts chip_reset
// - Driven reset pulse has guaranteed minimum length
// - Wipe pin requests flash and nvm reinit
// - Wipe debounced on slow clock, 200 ms
// - All port lines pulled-up inputs at reset
// - Each line pull-up set independently
// - Wipe clears boot-select nvm bit 2
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mode_pin_regs.svh"
module mode_pin_reset_control
	import mode_pin_pkg::*;
#(
	parameter int SLOW_DIV   = `SLOW_DIV,
	parameter int WIPE_TICKS = `WIPE_SLOW_TICKS
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        scan_select_pin,
	input  wire logic        test_mode_pin,
	input  wire logic        strap_line_zero,
	input  wire logic        strap_line_one,
	input  wire logic        strap_line_two,
	input  wire logic        flash_wipe_pin,
	input  wire logic        system_reset_pin_in,
	output logic             system_reset_pin_out,
	output logic             system_reset_pin_oe,
	input  wire logic        reset_cause,
	output logic             chip_reset,
	output logic             scan_mode,
	output logic             mfg_test_mode,
	output logic             fast_prog_mode,
	output logic             flash_wipe_req,
	output logic [30:0]      port_a_pullup_en,
	output logic [30:0]      port_b_pullup_en,
	output logic [30:0]      port_a_output_en,
	output logic [30:0]      port_b_output_en,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

////////////////////////////////////////////////////////////////////////////
	logic [6:0]  pins_sync;
	logic        scan_s, test_s, strap0_s, strap1_s, strap2_s;
	logic        wipe_s, rst_pin_s;
	logic        wipe_fire;
	op_mode_t    op_mode;
	op_mode_t    next_op_mode;
	logic        strap_bad;
	logic        wipe_done;
	logic        sw_reset;
	logic [2:0]  boot_nvm;
	logic [30:0] pullup_a, pullup_b;
	rst_state_t  rst_state;
	logic [7:0]  rst_count;
	logic        aw_held, w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// Reset pin idles high, so synchronise its inverse from zero
	sync2 #(.WIDTH(7)) u_sync (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.async_in    ({system_reset_pin_in, flash_wipe_pin, strap_line_two,
		               strap_line_one, strap_line_zero, test_mode_pin,
		               scan_select_pin}),
		.reset_value (7'h40),
		.sync_out    (pins_sync)
	);

	assign {rst_pin_s, wipe_s, strap2_s, strap1_s, strap0_s, test_s,
	        scan_s} = pins_sync;

	wipe_debounce #(.SLOW_DIV(SLOW_DIV), .WIPE_TICKS(WIPE_TICKS)) u_wipe (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.wipe_level (wipe_s),
		.wipe_fire  (wipe_fire)
	);

	function automatic logic wstrb_full(input logic [3:0] s);
		wstrb_full = &s;
	endfunction

////////////////////////////////////////////////////////////////////////////
	// Mode decode; bad straps fall back to manufacturing test
	always_comb begin
		if (scan_s)
			next_op_mode = op_scan;
		else if (test_s && strap0_s && strap1_s && !strap2_s)
			next_op_mode = op_fast_prog;
		else if (test_s)
			next_op_mode = op_mfg_test;
		else
			next_op_mode = op_normal;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_mode        <= op_normal;
			scan_mode      <= 1'b0;
			mfg_test_mode  <= 1'b0;
			fast_prog_mode <= 1'b0;
			strap_bad      <= 1'b0;
		end else begin
			op_mode        <= next_op_mode;
			scan_mode      <= (next_op_mode == op_scan);
			mfg_test_mode  <= (next_op_mode == op_mfg_test);
			fast_prog_mode <= (next_op_mode == op_fast_prog);
			// Undefined combination only flagged, not acted on
			strap_bad      <= test_s && !(strap0_s && strap1_s);
		end
	end

////////////////////////////////////////////////////////////////////////////
	// Reset pin: reset_cause or sw_reset stretched to a minimum low pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_state            <= rst_idle;
			rst_count            <= 8'h00;
			system_reset_pin_out <= 1'b0;
			system_reset_pin_oe  <= 1'b0;
			chip_reset           <= 1'b1;
		end else begin
			system_reset_pin_out <= 1'b0;
			case (rst_state)
				rst_idle: begin
					chip_reset <= rst_pin_s;
					if (reset_cause || sw_reset) begin
						rst_state           <= rst_drive;
						rst_count           <= 8'h00;
						system_reset_pin_oe <= 1'b1;
						chip_reset          <= 1'b1;
					end
				end
				rst_drive: begin
					chip_reset <= 1'b1;
					if (rst_count == 8'(`RST_PULSE_CYC - 1)
					    && !reset_cause) begin
						rst_state           <= rst_wait_release;
						system_reset_pin_oe <= 1'b0;
					end else if (rst_count != 8'(`RST_PULSE_CYC - 1)) begin
						rst_count <= rst_count + 8'h01;
					end
				end
				rst_wait_release: begin
					// Hold until the pin is seen high again
					if (!rst_pin_s) begin
						rst_state  <= rst_idle;
						chip_reset <= 1'b0;
					end
				end
				default: begin
					rst_state           <= rst_idle;
					system_reset_pin_oe <= 1'b0;
				end
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////
	// Pull-ups and port direction; chip reset restores pulled-up inputs
	always_ff @(posedge aclk) begin
		if (!aresetn || chip_reset) begin
			port_a_pullup_en <= `RST_PULLUP;
			port_b_pullup_en <= `RST_PULLUP;
			port_a_output_en <= 31'h00000000;
			port_b_output_en <= 31'h00000000;
		end else begin
			port_a_pullup_en <= pullup_a;
			port_b_pullup_en <= pullup_b;
			port_a_output_en <= 31'h00000000;
			port_b_output_en <= 31'h00000000;
		end
	end

	// Wipe request and boot bit; stored bits survive the chip reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_wipe_req <= 1'b0;
			boot_nvm       <= `RST_BOOT_NVM;
			wipe_done      <= 1'b0;
		end else begin
			flash_wipe_req <= wipe_fire;
			if (wipe_fire) begin
				boot_nvm[`FLD_BOOT_FLASH] <= 1'b0;
				wipe_done                 <= 1'b1;
			end else if (aw_held && w_held && !s_axi_bvalid) begin
				if (aw_addr == `REG_BOOT_NVM && w_strb[0])
					boot_nvm <= w_data[2:0];
				if (aw_addr == `REG_MODE_STATUS && w_strb[0]
				    && w_data[`FLD_WIPE_DONE])
					wipe_done <= 1'b0;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////
	// AXI write: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				case (aw_addr)
					`REG_MODE_STATUS, `REG_RESET_CTRL, `REG_PULLUP_A,
					`REG_PULLUP_B, `REG_BOOT_NVM: s_axi_bresp <= 2'h0;
					default: s_axi_bresp <= 2'h2;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_held       <= 1'b0;
				w_held        <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Pull-up registers need all lanes; partial writes ignored
	always_ff @(posedge aclk) begin
		if (!aresetn || chip_reset) begin
			pullup_a <= `RST_PULLUP;
			pullup_b <= `RST_PULLUP;
			sw_reset <= 1'b0;
		end else begin
			sw_reset <= 1'b0;
			if (aw_held && w_held && !s_axi_bvalid && wstrb_full(w_strb)) begin
				case (aw_addr)
					`REG_PULLUP_A: pullup_a <= w_data[30:0];
					`REG_PULLUP_B: pullup_b <= w_data[30:0];
					`REG_RESET_CTRL: sw_reset <= w_data[`FLD_SW_RESET];
					default: sw_reset <= 1'b0;
				endcase
			end
		end
	end

	// AXI read, one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'h0;
			case (s_axi_araddr)
				`REG_MODE_STATUS: s_axi_rdata <= {25'h0000000,
				    rst_pin_s, wipe_done, strap_bad, mfg_test_mode,
				    fast_prog_mode, test_s, scan_mode};
				`REG_RESET_CTRL: s_axi_rdata <= 32'h00000000;
				`REG_PULLUP_A: s_axi_rdata <= {1'b0, pullup_a};
				`REG_PULLUP_B: s_axi_rdata <= {1'b0, pullup_b};
				`REG_BOOT_NVM: s_axi_rdata <= {29'h00000000, boot_nvm};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== sim/board_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module board_model (
	input  wire logic       button,
	input  wire logic [2:0] cmd,
	input  wire logic       system_reset_pin_oe,
	input  wire logic       system_reset_pin_out,
	output logic            scan_select_pin,
	output logic            test_mode_pin,
	output logic            strap_line_zero,
	output logic            strap_line_one,
	output logic            strap_line_two,
	output logic            system_reset_pin_in
);
	// Straps zero and one tied high on the board, so test entry is never undefined
	assign strap_line_zero = 1'b1;
	assign strap_line_one = 1'b1;
	assign strap_line_two = cmd[0];
	assign scan_select_pin = cmd[2];
	assign test_mode_pin = cmd[1];
	// Pull-up when released; the button pulls low over anything
	assign system_reset_pin_in =
		!((system_reset_pin_oe && !system_reset_pin_out) || button);
endmodule
`default_nettype wire

// ==== sim/mode_pin_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mode_pin_regs.svh"
module mode_pin_props #(
	parameter int SLOW_DIV   = 4,
	parameter int WIPE_TICKS = 3
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        scan_select_pin,
	input wire logic        test_mode_pin,
	input wire logic        strap_line_zero,
	input wire logic        strap_line_one,
	input wire logic        strap_line_two,
	input wire logic        flash_wipe_pin,
	input wire logic        system_reset_pin_in,
	input wire logic        system_reset_pin_out,
	input wire logic        system_reset_pin_oe,
	input wire logic        reset_cause,
	input wire logic        chip_reset,
	input wire logic        scan_mode,
	input wire logic        mfg_test_mode,
	input wire logic        fast_prog_mode,
	input wire logic        flash_wipe_req,
	input wire logic [30:0] port_a_pullup_en,
	input wire logic [30:0] port_b_pullup_en,
	input wire logic [30:0] port_a_output_en,
	input wire logic [30:0] port_b_output_en
);
	localparam int MIN_PULSE = `RST_PULSE_CYC;
	logic [7:0] oe_len;
	int         wipe_len;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	// Saturates so a stuck driver cannot wrap under the limit
	always_ff @(posedge aclk) begin
		if (!aresetn || !system_reset_pin_oe)
			oe_len <= 8'h00;
		else if (oe_len != 8'hff)
			oe_len <= oe_len + 8'h01;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !flash_wipe_pin)
			wipe_len <= 0;
		else
			wipe_len <= wipe_len + 1;
	end
	sequence prog_straps;
		test_mode_pin && strap_line_zero && strap_line_one
			&& !strap_line_two && !scan_select_pin;
	endsequence
	sequence mfg_straps;
		test_mode_pin && strap_line_zero && strap_line_one
			&& strap_line_two && !scan_select_pin;
	endsequence
	sequence quiet_pins;
		!scan_select_pin && !test_mode_pin;
	endsequence
	////////////////////////////////////////////////////////////////////////
	scan_entry_a: assert property (
		scan_select_pin [*4] |-> scan_mode)
		else $error("scan mode not entered");
	fast_prog_a: assert property (
		prog_straps [*4] |-> fast_prog_mode)
		else $error("fast programming not entered");
	mfg_test_a: assert property (
		mfg_straps [*4] |-> mfg_test_mode && !fast_prog_mode)
		else $error("test mode not entered");
	normal_run_a: assert property (
		quiet_pins [*4] |-> !(scan_mode || mfg_test_mode || fast_prog_mode))
		else $error("mode active with pins low");
	one_mode_a: assert property (
		$onehot0({scan_mode, mfg_test_mode, fast_prog_mode}))
		else $error("several modes at once");
	drive_low_a: assert property (
		reset_cause && !chip_reset |=> system_reset_pin_oe
			&& !system_reset_pin_out)
		else $error("reset pin not pulled low");
	min_pulse_a: assert property (
		$fell(system_reset_pin_oe) |-> oe_len >= MIN_PULSE)
		else $error("reset pulse too short");
	ext_reset_a: assert property (
		!system_reset_pin_in |-> ##[1:4] chip_reset)
		else $error("external reset ignored");
	wipe_hold_a: assert property (
		flash_wipe_req |-> wipe_len >= (WIPE_TICKS - 1) * SLOW_DIV)
		else $error("wipe fired too early");
	wipe_once_a: assert property (
		flash_wipe_req |=> !flash_wipe_req [*8])
		else $error("wipe fired twice");
	pullup_reset_a: assert property (
		chip_reset [*2] |-> port_a_pullup_en == 31'h7fffffff
			&& port_b_pullup_en == 31'h7fffffff)
		else $error("pull-ups not restored");
	io_input_a: assert property (
		port_a_output_en == 31'h0 && port_b_output_en == 31'h0)
		else $error("line driven as output");
endmodule
bind mode_pin_reset_control mode_pin_props #(
	.SLOW_DIV  (SLOW_DIV),
	.WIPE_TICKS(WIPE_TICKS)
) props_i (
	.aclk, .aresetn, .scan_select_pin, .test_mode_pin, .strap_line_zero,
	.strap_line_one, .strap_line_two, .flash_wipe_pin, .system_reset_pin_in,
	.system_reset_pin_out, .system_reset_pin_oe, .reset_cause, .chip_reset,
	.scan_mode, .mfg_test_mode, .fast_prog_mode, .flash_wipe_req,
	.port_a_pullup_en, .port_b_pullup_en, .port_a_output_en,
	.port_b_output_en
);
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mode_pin_regs.svh"
module tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, reset_cause = 1'b0, button = 1'b0;
	logic flash_wipe_pin = 1'b0, seen = 1'b0, s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [2:0] cmd = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, q, v;
	logic [31:0] seed = 32'h00008a99; // Fixed seed, 35481
	logic [1:0] resp;
	logic [2:0] modes [4] = '{3'h0, 3'h4, 3'h2, 3'h3};
	wire logic scan_select_pin, test_mode_pin, strap_line_zero;
	wire logic strap_line_one, strap_line_two, system_reset_pin_in;
	wire logic system_reset_pin_out, system_reset_pin_oe, chip_reset;
	wire logic scan_mode, mfg_test_mode, fast_prog_mode, flash_wipe_req;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire logic s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [30:0] port_a_pullup_en, port_b_pullup_en;
	wire logic [30:0] port_a_output_en, port_b_output_en;
	wire logic [31:0] s_axi_rdata;
	int fails = 0, compares = 0, oe_cur = 0, oe_last = 0, pulses = 0, i;
	always #12.5 aclk = ~aclk;
	// Short slow-clock counts keep the wipe run brief
	mode_pin_reset_control #(.SLOW_DIV(4), .WIPE_TICKS(3)) dut (
		.aclk, .aresetn, .scan_select_pin, .test_mode_pin, .strap_line_zero,
		.strap_line_one, .strap_line_two, .flash_wipe_pin,
		.system_reset_pin_in, .system_reset_pin_out, .system_reset_pin_oe,
		.reset_cause, .chip_reset, .scan_mode, .mfg_test_mode,
		.fast_prog_mode, .flash_wipe_req, .port_a_pullup_en,
		.port_b_pullup_en, .port_a_output_en, .port_b_output_en,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	board_model partner (.button, .cmd, .system_reset_pin_oe,
		.system_reset_pin_out, .scan_select_pin, .test_mode_pin,
		.strap_line_zero, .strap_line_one, .strap_line_two,
		.system_reset_pin_in);
	////////////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function logic [2:0] exp_mode(input logic [2:0] c);
		if (c[2])
			return 3'h4;
		if (c[1])
			return c[0] ? 3'h2 : 3'h1;
		return 3'h0;
	endfunction
	task end_sim;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid) begin
				resp = s_axi_bresp;
				break;
			end
			if (s_axi_rready && s_axi_rvalid) begin
				resp = s_axi_rresp;
				q = s_axi_rdata;
				break;
			end
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (n == 64) begin
			fails++;
			end_sim();
		end
	endtask
	task settle;
		int n;
		for (n = 0; n < 400 && chip_reset !== 1'b0; n++)
			@(posedge aclk);
		if (n == 400) begin
			fails++;
			end_sim();
		end
	endtask
	// Reset pulse: pin must go low and stay low long enough
	task pulse_check;
		repeat (3) @(posedge aclk);
		chk(seen, 1);
		settle();
		@(posedge aclk);
		chk(oe_last >= `RST_PULSE_CYC, 1);
		bus(0, 12'h008, 0);
		chk(q, 32'h7fffffff);
	endtask
	always @(posedge aclk) begin
		if (system_reset_pin_oe === 1'b1) begin
			oe_cur <= oe_cur + 1;
			chk(system_reset_pin_in, 0);
		end else if (oe_cur != 0) begin
			oe_last <= oe_cur;
			oe_cur <= 0;
		end
		if (chip_reset === 1'b1)
			seen <= 1'b1;
		if (flash_wipe_req === 1'b1)
			pulses <= pulses + 1;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		bus(0, 12'h00c, 0);
		chk(q, 32'h7fffffff);
		chk({1'b0, port_a_output_en}, 0);
		repeat (4) begin
			v = rnd() & 32'h7fffffff;
			bus(1, 12'h008, v);
			bus(1, 12'h00c, ~v);
			bus(0, 12'h008, 0);
			chk(q, v);
			chk({1'b0, port_b_pullup_en}, ~v & 32'h7fffffff);
		end
		bus(0, 12'h020, 0);
		chk(resp, 2'h2);
		for (i = 0; i < 4; i++) begin
			cmd <= modes[i];
			repeat (6) @(posedge aclk);
			chk({scan_mode, mfg_test_mode, fast_prog_mode}, exp_mode(modes[i]));
		end
		cmd <= 3'h0;
		bus(1, 12'h010, 32'h4);
		// Glitch shorter than the debounce must be ignored
		flash_wipe_pin <= 1'b1;
		repeat (6) @(posedge aclk);
		flash_wipe_pin <= 1'b0;
		repeat (10) @(posedge aclk);
		chk(pulses, 0);
		flash_wipe_pin <= 1'b1;
		repeat (60) @(posedge aclk);
		flash_wipe_pin <= 1'b0;
		chk(pulses, 1);
		bus(0, 12'h010, 0);
		chk(q, 0);
		bus(0, 12'h000, 0);
		chk(q & 32'h20, 32'h20);
		seen <= 1'b0;
		oe_last <= 0;
		reset_cause <= 1'b1;
		@(posedge aclk);
		reset_cause <= 1'b0;
		pulse_check();
		seen <= 1'b0;
		oe_last <= 0;
		bus(1, 12'h004, 32'h1);
		pulse_check();
		seen <= 1'b0;
		button <= 1'b1;
		@(posedge aclk);
		button <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(seen, 1);
		settle();
		end_sim();
	end
endmodule
`default_nettype wire
